/* verification/tb.sv */
// self-checking testbench for the token network control core
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ==========================================
	// levels driven by the bench
	logic        ref_clk, rst, timing_refine_enable, init_idle_wait_bypass;
	logic        arb_clock_halving, cfg_reset_bit, line_idle, tx_flag_pulse, rx_flag_pulse;
	logic [5:0]  other_status;
	// host pulses from the model, and design outputs
	wire         station_wr, tentative_wr, next_station_rd, cmd_wr, mask_wr;
	wire  [7:0]  station_wdata, cmd_wdata, mask_wdata, ram_wdata_r, mask_r, cmd_code_r;
	wire  [2:0]  rate_prescale_select;
	wire         ram_we_r, init_done_r, arb_tick_r, rate_osc_tick_r, interrupt_out_n;
	wire         tx_available_flag, rx_inhibit_flag, soft_reset_r, probe_clear_r;
	wire         cmd_ready_r, cmd_accept_r;
	wire [10:0]  ram_addr_r;
	int          err_total = 0, num_checks = 0, n_acc = 0, n_prb = 0, n_arb = 0, hi, i;
	int          n_osc = 0; // rate ticks seen
	logic [18:0] wq[$]; // ram writes seen, address then data
	tnc_core u_dut (.ref_clk, .rst, .timing_refine_enable, .init_idle_wait_bypass,
		.arb_clock_halving, .rate_prescale_select, .cfg_reset_bit, .station_wr,
		.station_wdata, .tentative_wr, .next_station_rd, .cmd_wr, .cmd_wdata, .mask_wr,
		.mask_wdata, .line_idle, .tx_flag_pulse, .rx_flag_pulse, .other_status, .ram_we_r,
		.ram_addr_r, .ram_wdata_r, .init_done_r, .arb_tick_r, .rate_osc_tick_r,
		.interrupt_out_n, .tx_available_flag, .rx_inhibit_flag, .mask_r, .soft_reset_r,
		.probe_clear_r, .cmd_ready_r, .cmd_accept_r, .cmd_code_r);
	tnc_host_model u_host (.ref_clk, .station_wr, .station_wdata, .tentative_wr,
		.next_station_rd, .cmd_wr, .cmd_wdata, .mask_wr, .mask_wdata, .rate_prescale_select);
	// 200 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// event monitor: ram writes, accepts, probe clears, arb ticks
	always @(posedge ref_clk) begin
		if (ram_we_r) wq.push_back({ram_addr_r, ram_wdata_r});
		if (cmd_accept_r) n_acc++;
		if (probe_clear_r) n_prb++;
		// tick counts update late so window reads never race them
		if (arb_tick_r) n_arb <= n_arb + 1;
		if (rate_osc_tick_r) n_osc <= n_osc + 1;
	end
	// compare and count
	task automatic chk(input string nm, input logic [18:0] exp, input logic [18:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// verdict and end of run
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// bounded wait for the command path to be free
	task automatic wait_rdy;
		for (int j = 0; j < 100 && cmd_ready_r !== 1'b1; j++) @(posedge ref_clk);
		chk("cmd ready", 1, cmd_ready_r);
	endtask
	// disable request while interrupt low; measure the high stretch
	task automatic int_dis(input logic [2:0] k, input logic [7:0] d);
		u_host.access(k, d, 1'b0);
		for (int j = 0; j < 10 && interrupt_out_n !== 1'b1; j++) @(posedge ref_clk);
		chk("int released", 1, interrupt_out_n);
		hi = 0;
		while (interrupt_out_n === 1'b1 && hi < 400) begin
			@(posedge ref_clk);
			hi++;
		end
		chk("int high long enough", 1, hi >= 40);
		chk("int back low", 0, interrupt_out_n);
	endtask
	// watchdog, far beyond the expected run
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		conclude();
	end
	// main sequence
	initial begin
		{rst, timing_refine_enable, init_idle_wait_bypass, arb_clock_halving} = 4'h8;
		{cfg_reset_bit, line_idle, tx_flag_pulse, rx_flag_pulse} = 4'h0;
		other_status = 6'h00;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk("flags at reset", 2'b11, {tx_available_flag, rx_inhibit_flag});
		chk("mask at reset", 0, mask_r);
		// legacy: init waits for an idle line; no probe clear
		u_host.access(3'h0, 8'h05, 1'b0);
		u_host.access(3'h1, 8'h00, 1'b1);
		chk("ram held off", 0, wq.size());
		chk("legacy probe", 0, n_prb);
		line_idle <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk("ram count", 2, wq.size());
		chk("ram word0", {11'h000, 8'hD1}, wq[0]);
		chk("ram word1", {11'h001, 8'h05}, wq[1]);
		chk("init done", 1, init_done_r);
		// bypass: writes go ahead on a busy line
		line_idle <= 1'b0;
		init_idle_wait_bypass <= 1'b1;
		wq.delete();
		u_host.access(3'h0, 8'h3C, 1'b0);
		repeat (4) @(posedge ref_clk);
		chk("bypass count", 2, wq.size());
		chk("bypass word1", {11'h001, 8'h3C}, wq[1]);
		// legacy soft reset keeps the mask
		u_host.access(3'h4, 8'h0C, 1'b0);
		u_host.access(3'h0, 8'h00, 1'b0);
		repeat (5) @(posedge ref_clk);
		chk("legacy mask kept", 8'h0C, mask_r);
		// refined soft reset clears it, from both causes
		timing_refine_enable <= 1'b1;
		repeat (3) @(posedge ref_clk);
		u_host.access(3'h0, 8'h00, 1'b0);
		repeat (5) @(posedge ref_clk);
		chk("refined mask clear", 0, mask_r);
		u_host.access(3'h4, 8'h0C, 1'b0);
		cfg_reset_bit <= 1'b1;
		repeat (5) @(posedge ref_clk);
		chk("reset bit clears mask", 0, mask_r);
		cfg_reset_bit <= 1'b0;
		hi = n_prb;
		u_host.access(3'h1, 8'h00, 1'b0);
		repeat (4) @(posedge ref_clk);
		chk("probe clear", 1, n_prb - hi);
		// refined command spacing: second write too soon is dropped
		hi = n_acc;
		u_host.access(3'h3, 8'h03, 1'b0);
		repeat (2) @(posedge ref_clk);
		u_host.access(3'h3, 8'h04, 1'b0);
		repeat (5) @(posedge ref_clk);
		chk("one accept", 1, n_acc - hi);
		chk("cmd busy", 0, cmd_ready_r);
		chk("cmd code", 8'h03, cmd_code_r);
		chk("flags after enable", 2'b01, {tx_available_flag, rx_inhibit_flag});
		wait_rdy();
		u_host.access(3'h3, 8'h04, 1'b0);
		repeat (4) @(posedge ref_clk);
		chk("rx enable taken", 2, n_acc - hi);
		chk("cmd code rx", 8'h04, cmd_code_r);
		// refined flag rises only at pulse release
		tx_flag_pulse <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk("tx flag during pulse", 0, tx_available_flag);
		tx_flag_pulse <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("tx flag after pulse", 1, tx_available_flag);
		// legacy: flag rises at pulse start, then enable is prohibited
		timing_refine_enable <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rx_flag_pulse <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk("rx flag at pulse start", 1, rx_inhibit_flag);
		rx_flag_pulse <= 1'b0;
		wait_rdy();
		u_host.access(3'h3, 8'h04, 1'b0);
		repeat (4) @(posedge ref_clk);
		chk("enable prohibited", 1, rx_inhibit_flag);
		repeat (60) @(posedge ref_clk);
		wait_rdy();
		u_host.access(3'h3, 8'h04, 1'b0);
		repeat (4) @(posedge ref_clk);
		chk("enable after window", 0, rx_inhibit_flag);
		// interrupt disable by each trigger: clear int legacy, clear flag refined, next station read legacy
		u_host.access(3'h4, 8'h04, 1'b0);
		other_status <= 6'h01;
		for (i = 0; i < 3; i++) begin
			timing_refine_enable <= i[0];
			wait_rdy();
			repeat (4) @(posedge ref_clk);
			chk("int asserted", 0, interrupt_out_n);
			int_dis(i == 2 ? 3'h2 : 3'h3, i[7:0] + 8'h01);
		end
		// arbitration tick rate, full and halved
		for (i = 0; i < 2; i++) begin
			arb_clock_halving <= i[0];
			repeat (40) @(posedge ref_clk);
			hi = n_arb;
			repeat (200) @(posedge ref_clk);
			chk("arb ticks", i[0] ? 10 : 20, n_arb - hi);
		end
		// rate tick: legacy takes a new select at once, refined at a wrap
		u_host.set_sel(3'h1);
		repeat (40) @(posedge ref_clk);
		hi = n_osc;
		repeat (200) @(posedge ref_clk);
		chk("legacy rate ticks", 10, n_osc - hi);
		timing_refine_enable <= 1'b1;
		u_host.set_sel(3'h2);
		repeat (1400) @(posedge ref_clk);
		hi = n_osc;
		repeat (200) @(posedge ref_clk);
		chk("refined rate ticks", 5, n_osc - hi);
		conclude();
	end
endmodule // tb
`default_nettype wire

/* verification/tnc_core_sva.sv */
// assertion checker for the token network control core
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// checker module
module tnc_core_sva (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// configuration levels
	input wire logic        timing_refine_enable,
	input wire logic        init_idle_wait_bypass,
	input wire logic        arb_clock_halving,
	// host pulses
	input wire logic        station_wr,
	input wire logic [7:0]  station_wdata,
	input wire logic        tentative_wr,
	input wire logic        cmd_wr,
	// results
	input wire logic        ram_we_r,
	input wire logic [10:0] ram_addr_r,
	input wire logic [7:0]  ram_wdata_r,
	input wire logic        arb_tick_r,
	input wire logic        interrupt_out_n,
	input wire logic        tx_available_flag,
	input wire logic        rx_inhibit_flag,
	input wire logic [7:0]  mask_r,
	input wire logic        soft_reset_r,
	input wire logic        probe_clear_r,
	input wire logic        cmd_accept_r
);
	logic [5:0] cyc_r;   // cycles since reset, saturating
	logic [5:0] cyc_nxt; // next count
	assign cyc_nxt = (cyc_r == 6'h3F) ? cyc_r : cyc_r + 6'h01;
	// warm-up count keeps deep history away from reset values
	always_ff @(posedge ref_clk) begin
		if (rst) cyc_r <= 6'h00;
		else cyc_r <= cyc_nxt;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_ARB_FULL:
		assert property (cyc_r > 6'h2D && arb_tick_r && !arb_clock_halving
			&& !$past(arb_clock_halving, 20) |-> $past(arb_tick_r, 10))
		else $error("arb tick not one crystal tick apart");
	AST_ARB_HALF:
		assert property (cyc_r > 6'h2D && arb_tick_r && arb_clock_halving
			&& $past(arb_clock_halving, 20) && $past(arb_clock_halving, 40)
			|-> $past(arb_tick_r, 20) && !$past(arb_tick_r, 10))
		else $error("halved arb tick not two crystal ticks apart");
	AST_INT_HOLD:
		assert property ($rose(interrupt_out_n) |-> interrupt_out_n [*8])
		else $error("interrupt reasserted too soon");
	AST_INIT_GO:
		assert property ($past(station_wr, 2) && $past(station_wdata, 2) != 8'h00
			&& $past(init_idle_wait_bypass, 2) |-> ram_we_r && ram_addr_r == 11'h000)
		else $error("bypassed init write did not start");
	AST_RAM_PAIR:
		assert property (ram_we_r && ram_addr_r == 11'h000 |-> ram_wdata_r == 8'hD1
			##1 ram_we_r && ram_addr_r == 11'h001)
		else $error("init ram image wrong");
	AST_SOFT_ZERO:
		assert property ($past(station_wr, 2) && $past(station_wdata, 2) == 8'h00
			|-> soft_reset_r)
		else $error("zero station gave no soft reset");
	AST_SOFT_FLAGS:
		assert property (soft_reset_r |-> ##[0:1] tx_available_flag && rx_inhibit_flag)
		else $error("soft reset left a flag low");
	AST_MASK_CLR:
		assert property (soft_reset_r && timing_refine_enable
			&& $past(timing_refine_enable, 3) |-> ##[0:1] mask_r == 8'h00)
		else $error("refined soft reset kept mask");
	AST_PROBE:
		assert property (tentative_wr && timing_refine_enable
			&& $past(timing_refine_enable) |-> ##2 probe_clear_r)
		else $error("probe effects not cleared");
	AST_CMD_CAUSE:
		assert property (cmd_accept_r |-> $past(cmd_wr, 2))
		else $error("command accepted without a write");
endmodule // tnc_core_sva
bind tnc_core tnc_core_sva u_sva (.*);
`default_nettype wire

/* verification/tnc_host_model.sv */
// host microcontroller model issuing access pulses into the core
`timescale 1ns/1ps
`default_nettype none
module tnc_host_model (
	// clock
	input  wire logic      ref_clk,
	// access pulses and data
	output var logic       station_wr,
	output var logic [7:0] station_wdata,
	output var logic       tentative_wr,
	output var logic       next_station_rd,
	output var logic       cmd_wr,
	output var logic [7:0] cmd_wdata,
	output var logic       mask_wr,
	output var logic [7:0] mask_wdata,
	// prescaler select level
	output var logic [2:0] rate_prescale_select
);
	// quiet bus at time zero; select starts at zero
	initial begin
		{station_wr, tentative_wr, next_station_rd, cmd_wr, mask_wr} = 5'h00;
		{station_wdata, cmd_wdata, mask_wdata} = 24'h000000;
		rate_prescale_select = 3'h0;
	end
	// one access: single-cycle pulse, then data released to a changed value
	task automatic access(input logic [2:0] k, input logic [7:0] d, input logic sp);
		@(posedge ref_clk);
		case (k)
			3'h0: begin station_wr <= 1'b1; station_wdata <= d; end
			3'h1: tentative_wr <= 1'b1;
			3'h2: next_station_rd <= 1'b1;
			3'h3: begin cmd_wr <= 1'b1; cmd_wdata <= d; end
			default: begin mask_wr <= 1'b1; mask_wdata <= d; end
		endcase
		@(posedge ref_clk);
		{station_wr, tentative_wr, next_station_rd, cmd_wr, mask_wr} <= 5'h00;
		{station_wdata, cmd_wdata, mask_wdata} <= ~{station_wdata, cmd_wdata, mask_wdata};
		// optional quiet gap of several arbitration periods
		if (sp) repeat (50) @(posedge ref_clk);
	endtask
	// new select just after an edge; modelled rate stays under 5 Mbps
	task automatic set_sel(input logic [2:0] s);
		@(posedge ref_clk);
		rate_prescale_select <= s;
	endtask
endmodule // tnc_host_model
`default_nettype wire

/* verilog/tnc_core.v */
// control core of the token network controller
// Operation
// - arbitration tick equals or halves operation
// - interrupt held high before reasserting
// - bypass bit skips idle wait
// - nonzero station write starts two ram writes
// - bypass suppresses idle wait in init
// - refinement enable resets to legacy
// - clear commands or read disable interrupt
// - refined disable clock stays under 20 MHz
// - prescaler select synchronised when refined
// - command write interval per clock source
// - legacy enable command prohibition window
// - refined flags rise at pulse release
// - refined station writes clear probe effects
// - mask cleared by soft reset refined
// - soft reset on zero station or bit
// - soft reset sets both flags
`timescale 1ns/1ps
`default_nettype none
`include "tnc_core_regs.vh"

module tnc_core #(
	parameter SEL_W = 3  // prescaler select width
) (
	// clock and reset
	input  wire             ref_clk,
	input  wire             rst,
	// configuration levels from the host
	input  wire             timing_refine_enable,
	input  wire             init_idle_wait_bypass,
	input  wire             arb_clock_halving,
	input  wire [SEL_W-1:0] rate_prescale_select,
	input  wire             cfg_reset_bit,
	// host access pulses
	input  wire             station_wr,
	input  wire [7:0]       station_wdata,
	input  wire             tentative_wr,
	input  wire             next_station_rd,
	input  wire             cmd_wr,
	input  wire [7:0]       cmd_wdata,
	input  wire             mask_wr,
	input  wire [7:0]       mask_wdata,
	// network side
	input  wire             line_idle,
	input  wire             tx_flag_pulse,
	input  wire             rx_flag_pulse,
	input  wire [5:0]       other_status,
	// ram write port
	output reg              ram_we_r,
	output reg  [10:0]      ram_addr_r,
	output reg  [7:0]       ram_wdata_r,
	output reg              init_done_r,
	// clocks as enables
	output reg              arb_tick_r,
	output reg              rate_osc_tick_r,
	// status and control results
	output reg              interrupt_out_n,
	output reg              tx_available_flag,
	output reg              rx_inhibit_flag,
	output reg  [7:0]       mask_r,
	output reg              soft_reset_r,
	output reg              probe_clear_r,
	output reg              cmd_ready_r,
	output reg              cmd_accept_r,
	output reg  [7:0]       cmd_code_r
);

	// ==========================================================
	// host capture stage
	reg             refine_r;      // refinement enable, captured
	reg             byp_r;         // idle wait bypass, captured
	reg             halve_r;       // arbitration halving, captured
	reg [SEL_W-1:0] sel_cap_r;     // prescaler select, captured
	reg             rstbit_r;      // reset bit, captured
	reg             rstbit_d_r;    // previous reset bit for edge
	reg             st_wr_r;       // station write, captured
	reg [7:0]       st_data_r;     // station value
	reg             tent_wr_r;     // tentative write, captured
	reg             nxt_rd_r;      // next station read, captured
	reg             cmd_wr_r;      // command write, captured
	reg [7:0]       cmd_data_r;    // command value
	reg             mask_wr_r;     // mask write, captured
	reg [7:0]       mask_data_r;   // mask value

	// every host value passes one register so decode sees stable data
	always @(posedge ref_clk) begin
		if (rst) begin
			refine_r    <= 1'b0;
			byp_r       <= 1'b0;
			halve_r     <= 1'b0;
			sel_cap_r   <= {SEL_W{1'b0}};
			rstbit_r    <= 1'b0;
			rstbit_d_r  <= 1'b0;
			st_wr_r     <= 1'b0;
			st_data_r   <= 8'h00;
			tent_wr_r   <= 1'b0;
			nxt_rd_r    <= 1'b0;
			cmd_wr_r    <= 1'b0;
			cmd_data_r  <= 8'h00;
			mask_wr_r   <= 1'b0;
			mask_data_r <= 8'h00;
		end else begin
			refine_r    <= timing_refine_enable;
			byp_r       <= init_idle_wait_bypass;
			halve_r     <= arb_clock_halving;
			sel_cap_r   <= rate_prescale_select;
			rstbit_r    <= cfg_reset_bit;
			rstbit_d_r  <= rstbit_r;
			st_wr_r     <= station_wr;
			tent_wr_r   <= tentative_wr;
			nxt_rd_r    <= next_station_rd;
			cmd_wr_r    <= cmd_wr;
			mask_wr_r   <= mask_wr;
			if (station_wr)
				st_data_r <= station_wdata;
			if (cmd_wr)
				cmd_data_r <= cmd_wdata;
			if (mask_wr)
				mask_data_r <= mask_wdata;
		end
	end

	// ==========================================================
	// clock enables
	wire       xtal_en;  // crystal rate tick
	wire       slow_en;  // half crystal, under 20 MHz
	reg        arb_ph_r; // phase for halved arbitration
	reg [6:0]  pre_cnt_r;               // prescaler counter
	reg [SEL_W-1:0] sel_s1_r;           // select sync stage one
	reg [SEL_W-1:0] sel_s2_r;           // select sync stage two
	reg [SEL_W-1:0] sel_use_r;          // select applied at wrap
	wire [SEL_W-1:0] sel_eff;           // select actually in force
	wire [6:0] pre_mask;                // counter bits that must be ones
	// crystal period in clocks, kept 32 bits so it can be sliced
	localparam [31:0] XTAL_DIV = `TNC_XTAL_CYC;

	tnc_divider #(.W(8)) u_xtal_div (
		.ref_clk (ref_clk),
		.rst     (rst),
		.tick_in (1'b1),
		.div     (XTAL_DIV[7:0]),
		.pulse_r (xtal_en)
	);

	tnc_divider #(.W(8)) u_slow_div (
		.ref_clk (ref_clk),
		.rst     (rst),
		.tick_in (xtal_en),
		.div     (`TNC_SLOW_DIV),
		.pulse_r (slow_en)
	);

	// legacy mode feeds raw select straight in, so it may glitch
	assign sel_eff  = refine_r ? sel_use_r : sel_cap_r;
	assign pre_mask = ~(7'h7F << sel_eff);

	// operation clock is the crystal; arbitration may halve it
	always @(posedge ref_clk) begin
		if (rst) begin
			arb_ph_r        <= 1'b0;
			arb_tick_r      <= 1'b0;
			pre_cnt_r       <= 7'h00;
			sel_s1_r        <= {SEL_W{1'b0}};
			sel_s2_r        <= {SEL_W{1'b0}};
			sel_use_r       <= {SEL_W{1'b0}};
			rate_osc_tick_r <= 1'b0;
		end else begin
			arb_tick_r      <= 1'b0;
			rate_osc_tick_r <= 1'b0;
			sel_s1_r        <= sel_cap_r;
			sel_s2_r        <= sel_s1_r;
			if (xtal_en) begin
				arb_ph_r   <= ~arb_ph_r;
				arb_tick_r <= ~halve_r | arb_ph_r;
				pre_cnt_r  <= pre_cnt_r + 7'h01;
				if ((pre_cnt_r & pre_mask) == pre_mask)
					rate_osc_tick_r <= 1'b1;
				// new select only at a full wrap: no short output period
				if (pre_cnt_r == 7'h7F)
					sel_use_r <= sel_s2_r;
			end
		end
	end

	// picks legacy rate tick or refined crystal based tick
	function pick_tick;
		input refine;
		input legacy_tick;
		input refined_tick;
		begin
			pick_tick = refine ? refined_tick : legacy_tick;
		end
	endfunction

	// ==========================================================
	// soft reset and probe cleanup
	wire soft_rst_ev; // soft reset cause this cycle

	assign soft_rst_ev = (st_wr_r && st_data_r == `TNC_STATION_SOFT_RST) ||
	                     (rstbit_r && !rstbit_d_r);

	// one pulse per cause; probe clear only when refined
	always @(posedge ref_clk) begin
		if (rst) begin
			soft_reset_r  <= 1'b0;
			probe_clear_r <= 1'b0;
		end else begin
			soft_reset_r  <= soft_rst_ev;
			probe_clear_r <= refine_r & (st_wr_r | tent_wr_r);
		end
	end

	// ==========================================================
	// command acceptance
	reg [3:0] cmd_cnt_r;    // ticks since last accepted command
	reg [3:0] proh_cnt_r;   // legacy prohibition ticks left
	wire      cmd_tick;     // tick for the interval counter
	wire      cmd_ok;       // command taken this cycle
	wire      is_enable;    // enable transmit or receive

	assign cmd_tick  = pick_tick(refine_r, rate_osc_tick_r, xtal_en);
	assign is_enable = (cmd_data_r == `TNC_CMD_EN_TX) || (cmd_data_r == `TNC_CMD_EN_RX);
	// enable commands inside the prohibition window are dropped
	assign cmd_ok    = cmd_wr_r && cmd_ready_r && !(is_enable && proh_cnt_r != 4'h0);

	// interval timer blocks writes that come too close together
	always @(posedge ref_clk) begin
		if (rst) begin
			cmd_cnt_r    <= 4'h0;
			cmd_ready_r  <= 1'b1;
			cmd_accept_r <= 1'b0;
			cmd_code_r   <= 8'h00;
		end else begin
			cmd_accept_r <= cmd_ok;
			if (cmd_ok) begin
				cmd_code_r  <= cmd_data_r;
				cmd_ready_r <= 1'b0;
				cmd_cnt_r   <= 4'h0;
			end else if (!cmd_ready_r && cmd_tick) begin
				cmd_cnt_r <= cmd_cnt_r + 4'h1;
				if (cmd_cnt_r + 4'h1 >= `TNC_CMD_TICKS)
					cmd_ready_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// transmit and receive flags
	reg tx_pulse_d_r; // flag pulse of last cycle
	reg rx_pulse_d_r;
	wire tx_set;      // flag returns high now
	wire rx_set;
	wire tx_clr;      // enable transmit accepted
	wire rx_clr;      // enable receive accepted

	// legacy rises at pulse start, refined at its release
	assign tx_set = refine_r ? (tx_pulse_d_r && !tx_flag_pulse)
	                         : (tx_flag_pulse && !tx_pulse_d_r);
	assign rx_set = refine_r ? (rx_pulse_d_r && !rx_flag_pulse)
	                         : (rx_flag_pulse && !rx_pulse_d_r);
	assign tx_clr = cmd_ok && cmd_data_r == `TNC_CMD_EN_TX;
	assign rx_clr = cmd_ok && cmd_data_r == `TNC_CMD_EN_RX;

	// a set beats a clear arriving in the same cycle
	always @(posedge ref_clk) begin
		if (rst) begin
			tx_pulse_d_r      <= 1'b0;
			rx_pulse_d_r      <= 1'b0;
			tx_available_flag <= 1'b1;
			rx_inhibit_flag   <= 1'b1;
			proh_cnt_r        <= 4'h0;
		end else begin
			tx_pulse_d_r <= tx_flag_pulse;
			rx_pulse_d_r <= rx_flag_pulse;
			if (soft_rst_ev || tx_set)
				tx_available_flag <= 1'b1;
			else if (tx_clr)
				tx_available_flag <= 1'b0;
			if (soft_rst_ev || rx_set)
				rx_inhibit_flag <= 1'b1;
			else if (rx_clr)
				rx_inhibit_flag <= 1'b0;
			// legacy window opens on the early flag rise
			if (!refine_r && (tx_set || rx_set))
				proh_cnt_r <= `TNC_PROHIB_TICKS;
			else if (refine_r)
				proh_cnt_r <= 4'h0;
			else if (proh_cnt_r != 4'h0 && rate_osc_tick_r)
				proh_cnt_r <= proh_cnt_r - 4'h1;
		end
	end

	// ==========================================================
	// mask and interrupt
	wire [7:0] status_bits; // status seen by the mask
	wire       irq_raw;     // any unmasked status
	wire       irq_tick;    // tick for the disable count
	wire       dis_ev;      // disable request while active
	reg  [3:0] dis_cnt_r;   // disable ticks still to run
	reg  [3:0] hold_cnt_r;  // high time ticks still to run

	assign status_bits = {other_status, rx_inhibit_flag, tx_available_flag};
	assign irq_raw     = |(status_bits & mask_r);
	assign irq_tick    = pick_tick(refine_r, rate_osc_tick_r, slow_en);
	assign dis_ev      = !interrupt_out_n && (nxt_rd_r || (cmd_ok &&
	                     (cmd_data_r == `TNC_CMD_CLR_INT || cmd_data_r == `TNC_CMD_CLR_FLAG)));

	// mask keeps value over soft reset in legacy mode
	always @(posedge ref_clk) begin
		if (rst)
			mask_r <= 8'h00;
		else if (soft_rst_ev && refine_r)
			mask_r <= 8'h00;
		else if (mask_wr_r)
			mask_r <= mask_data_r;
	end

	// counts one extra tick so a partial first period is covered
	always @(posedge ref_clk) begin
		if (rst) begin
			interrupt_out_n <= 1'b1;
			dis_cnt_r       <= 4'h0;
			hold_cnt_r      <= 4'h0;
		end else begin
			if (dis_ev) begin
				dis_cnt_r <= `TNC_DIS_TICKS;
			end else if (dis_cnt_r != 4'h0 && irq_tick) begin
				dis_cnt_r <= dis_cnt_r - 4'h1;
			end
			if (!interrupt_out_n && (dis_ev || !irq_raw)) begin
				interrupt_out_n <= 1'b1;
				hold_cnt_r      <= `TNC_HOLD_TICKS;
			end else if (hold_cnt_r != 4'h0) begin
				if (pick_tick(refine_r, rate_osc_tick_r, xtal_en))
					hold_cnt_r <= hold_cnt_r - 4'h1;
			end else if (interrupt_out_n && irq_raw && dis_cnt_r == 4'h0) begin
				interrupt_out_n <= 1'b0;
			end
		end
	end

	// ==========================================================
	// initialization ram writes
	localparam S_IDLE = 5'b00001; // nothing pending
	localparam S_WAIT = 5'b00010; // waiting for an idle line
	localparam S_WR0  = 5'b00100; // first image byte
	localparam S_WR1  = 5'b01000; // station byte
	localparam S_DONE = 5'b10000; // image written

	reg [4:0] st_r;   // init sequencer state
	reg [4:0] st_nxt;

	// bypass decodes the init routine and drops its idle wait
	always @* begin
		st_nxt = st_r;
		case (st_r)
			S_IDLE: st_nxt = S_IDLE;
			S_WAIT: if (byp_r || line_idle)
				st_nxt = S_WR0;
			S_WR0:  st_nxt = S_WR1;
			S_WR1:  st_nxt = S_DONE;
			S_DONE: st_nxt = S_DONE;
			default: st_nxt = S_IDLE;
		endcase
		if (st_wr_r && st_data_r != `TNC_STATION_SOFT_RST)
			st_nxt = byp_r ? S_WR0 : S_WAIT;
		else if (soft_rst_ev)
			st_nxt = S_IDLE;
	end

	// two writes back to back, well inside the init time limit
	always @(posedge ref_clk) begin
		if (rst) begin
			st_r        <= S_IDLE;
			ram_we_r    <= 1'b0;
			ram_addr_r  <= 11'h000;
			ram_wdata_r <= 8'h00;
			init_done_r <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			ram_we_r <= 1'b0;
			init_done_r <= (st_nxt == S_DONE);
			if (st_nxt == S_WR0) begin
				ram_we_r    <= 1'b1;
				ram_addr_r  <= `TNC_INIT_ADDR0;
				ram_wdata_r <= `TNC_INIT_DATA0;
			end else if (st_nxt == S_WR1) begin
				ram_we_r    <= 1'b1;
				ram_addr_r  <= `TNC_INIT_ADDR1;
				ram_wdata_r <= st_data_r;
			end
		end
	end

endmodule // tnc_core
`default_nettype wire

/* verilog/tnc_core_regs.vh */
// constants for the token network control core
`ifndef TNC_CORE_REGS_VH
`define TNC_CORE_REGS_VH

// ==========================================================
// clock and time figures
`define TNC_CLK_PS            32'd5000
`define TNC_XTAL_PS           32'd50000
`define TNC_XTAL_CYC          (`TNC_XTAL_PS / `TNC_CLK_PS)
`define TNC_INIT_LIMIT_NS     32'd6000
`define TNC_INIT_LIMIT_CYC    ((`TNC_INIT_LIMIT_NS * 32'd1000) / `TNC_CLK_PS)

// ==========================================================
// tick counts on the selected slow clocks, and the slow divide ratio
`define TNC_DIS_TICKS         4'h5
`define TNC_HOLD_TICKS        4'h5
`define TNC_CMD_TICKS         4'h2
`define TNC_PROHIB_TICKS      4'h4
`define TNC_SLOW_DIV          8'h02

// ==========================================================
// initialization ram image
`define TNC_INIT_ADDR0        11'h000
`define TNC_INIT_ADDR1        11'h001
`define TNC_INIT_DATA0        8'hD1
`define TNC_STATION_SOFT_RST  8'h00

// ==========================================================
// command codes
`define TNC_CMD_CLR_INT       8'h01
`define TNC_CMD_CLR_FLAG      8'h02
`define TNC_CMD_EN_TX         8'h03
`define TNC_CMD_EN_RX         8'h04

// ==========================================================
// status bit positions
`define TNC_ST_TX_AVAIL       0
`define TNC_ST_RX_INHIBIT     1

`endif

/* verilog/tnc_divider.v */
// enable pulse divider for the token network control core
`timescale 1ns/1ps
`default_nettype none

module tnc_divider #(
	parameter W = 8
) (
	// clock and reset
	input  wire         ref_clk,
	input  wire         rst,
	// tick to divide and ratio
	input  wire         tick_in,
	input  wire [W-1:0] div,
	// one pulse every div ticks
	output reg          pulse_r
);

	// ==========================================================
	// counter
	reg [W-1:0] cnt_r; // ticks seen in this period

	// counts input ticks, pulses on the last one
	always @(posedge ref_clk) begin
		if (rst) begin
			cnt_r   <= {W{1'b0}};
			pulse_r <= 1'b0;
		end else begin
			pulse_r <= 1'b0;
			if (tick_in) begin
				if (cnt_r >= div - {{(W-1){1'b0}}, 1'b1}) begin
					cnt_r   <= {W{1'b0}};
					pulse_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule // tnc_divider
`default_nettype wire
